//--- hmdc_pkg.sv
package hmdc_pkg;
   // clock and carrier timing
   localparam int CLK_HZ = 250_000_000;
   localparam int CARRIER_US = 50;
   localparam int TICK_CYC = CLK_HZ / 1_000_000 * CARRIER_US;
   // potentiometer speed scaling
   localparam logic [11:0] POT_ZERO_CW = 12'h800;
   localparam logic [11:0] POT_ZERO_CCW = 12'h7FF;
   localparam int POT_SPAN = 2047;
   localparam int SPD_MAX_RPM = 2400;
   // a/d full scale and physical spans
   localparam int ADC_FS = 4095;
   localparam int VBUS_FS_CV = 7326;
   localparam int I_SPAN_MA = 16500;
   localparam int I_OFS_MA = 8250;
   // protection defaults, centivolts
   localparam int OV_CV = 6000;
   localparam int UV_CV = 800;
   // fixed point: one revolution and unit ratio
   localparam int REV_Q = 65536;
   localparam int MOD_SHIFT = 15;
   localparam int SECTORS = 6;
   localparam logic [2:0] HIST_FULL = 3'h6;
   // register addresses
   localparam logic [3:0] A_CTRL = 4'h0;
   localparam logic [3:0] A_HSPD = 4'h1;
   localparam logic [3:0] A_STAT = 4'h2;
   localparam logic [3:0] A_SCMD = 4'h3;
   localparam logic [3:0] A_VBUS = 4'h4;
   localparam logic [3:0] A_AINC = 4'h5;
   localparam logic [3:0] A_RSUM = 4'h6;
   // control register bit positions
   localparam int C_RUN = 0;
   localparam int C_STOP = 1;
   localparam int C_RST = 2;
   localparam int C_HOST = 3;
   localparam int C_SV = 4;
   // operating modes
   typedef enum logic [1:0] {ST_STOP, ST_DRIVE, ST_FAULT} hmdc_mode_t;
   // three phase word group
   typedef struct packed {
      logic signed [15:0] u;
      logic signed [15:0] v;
      logic signed [15:0] w;
   } hmdc_phase_t;
   // raw a/d sample group
   typedef struct packed {
      logic [11:0] pot;
      logic [11:0] vbus;
      logic [11:0] iu;
      logic [11:0] iv;
      logic [11:0] iw;
   } hmdc_adc_t;
   // whole block state
   typedef struct packed {
      hmdc_mode_t mode;
      logic swPrev;
      logic hostSel;
      logic svSel;
      logic signed [15:0] hostSpd;
      logic [15:0] tickCnt;
      logic tick;
      logic [2:0] hallPrev;
      logic hallPrime;
      logic hallSeen;
      logic [15:0] secCnt;
      logic [5:0][15:0] hist;
      logic [2:0] histCnt;
      logic dirCw;
      logic [15:0] baseAng;
      logic [18:0] revSum;
      logic sumValid;
      logic [15:0] angInc;
      logic signed [15:0] speedCmd;
      logic [15:0] busVolt;
      hmdc_phase_t cur;
      hmdc_phase_t wave;
      logic [15:0] modRatio;
      logic pwmEn;
      logic [15:0] rdData;
   } hmdc_state_t;
endpackage : hmdc_pkg

//--- hmdc_top.sv
// Overview of operation
// - host command or switch starts/stops motor
// - switch high starts, falling low stops
// - speed command from host or potentiometer
// - 800h..FFFh maps to CW 0..2400 rpm
// - 7FFh..000h maps to CCW 0..2400 rpm
// - bus voltage feeds ratio, limits stop PWM
// - phase currents scale -8.25..+8.25 A
// - config bit selects sine or space vector
// - sine ratio is reference over bus voltage
// - space vector subtracts mid of max/min
// - offset keeps line voltages, full utilization
// - space vector ratio uses adjusted phase voltage
// - three modes, changed only by events
// - stop/run/reset user, error internal
// - hall sampled each 50 us carrier tick
// - ticks counted per 60 degree sector
// - speed uses sum of six sectors
// - increment is revolution over tick sum
// - CW hall order 1,5,4,6,2,3 base angles
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module hmdc_top
   import hmdc_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int OV_LIMIT = OV_CV,
   parameter int UV_LIMIT = UV_CV
)(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   // switch and hall pins
   input wire logic startStopSwitch,
   input wire logic [2:0] hallIn,
   // a/d samples
   input wire hmdc_adc_t adcIn,
   input wire logic adcValid,
   // current controller voltage commands, centivolts
   input wire hmdc_phase_t phaseCmd,
   input wire logic [15:0] refVolt,
   // drive outputs
   output logic pwmEnable,
   output hmdc_mode_t modeOut,
   output hmdc_phase_t modWave,
   output logic [15:0] modRatio,
   output hmdc_phase_t phaseCurrent,
   output logic signed [15:0] speedCmd,
   output logic [15:0] busVolt,
   // hall speed outputs
   output logic [15:0] angleInc,
   output logic [15:0] baseAngle,
   output logic dirCw,
   output logic speedValid
);

   hmdc_state_t s_ff; // registered state
   hmdc_state_t nxt_s; // next state

   // request and event terms
   logic runReq;
   logic stopReq;
   logic rstReq;
   logic errEvt;
   // scaling temporaries
   int vbNew;
   int potRpm;
   int sumTmp;
   // modulation temporaries
   logic signed [16:0] vMax;
   logic signed [16:0] vMin;
   logic signed [16:0] dv;
   logic signed [16:0] wu;
   logic signed [16:0] wv;
   logic signed [16:0] ww;
   logic [15:0] vPeak;
   logic [2:0] idxNew;
   logic [2:0] idxOld;

   // hall pattern to sector index, 7 marks illegal
   function automatic logic [2:0] hallIdx(input logic [2:0] h);
      logic [2:0] r;
      r = 3'h7;
      case (h)
         3'h1: r = 3'h0;
         3'h5: r = 3'h1;
         3'h4: r = 3'h2;
         3'h6: r = 3'h3;
         3'h2: r = 3'h4;
         3'h3: r = 3'h5;
         default: r = 3'h7;
      endcase
      return r;
   endfunction : hallIdx

   // a/d code to signed milliamps
   function automatic logic signed [15:0] toMa(input logic [11:0] c);
      int t;
      t = int'(c) * I_SPAN_MA / ADC_FS - I_OFS_MA;
      return 16'(t);
   endfunction : toMa

   // signed magnitude helper
   function automatic logic [15:0] mag(input logic signed [16:0] x);
      logic signed [16:0] a;
      a = (x < 0) ? -x : x;
      return a[15:0];
   endfunction : mag

   // next state logic
   always_comb
   begin
      nxt_s = s_ff;
      runReq = 1'b0;
      stopReq = 1'b0;
      rstReq = 1'b0;
      vbNew = 0;
      potRpm = 0;
      sumTmp = 0;
      idxNew = hallIdx(hallIn);
      idxOld = hallIdx(s_ff.hallPrev);
      nxt_s.tick = 1'b0;
      nxt_s.rdData = 16'h0000;

      // carrier tick divider
      if (s_ff.tickCnt == 16'(TICK_CYCLES - 1))
      begin
         nxt_s.tickCnt = 16'h0000;
         nxt_s.tick = 1'b1;
      end
      else
      begin
         nxt_s.tickCnt = s_ff.tickCnt + 16'h0001;
      end

      // register writes
      if (regWr)
      begin
         case (regAddr)
            A_CTRL:
            begin
               runReq = regWrData[C_RUN];
               stopReq = regWrData[C_STOP];
               rstReq = regWrData[C_RST];
               nxt_s.hostSel = regWrData[C_HOST];
               nxt_s.svSel = regWrData[C_SV];
            end
            A_HSPD: nxt_s.hostSpd = regWrData;
            default: ;
         endcase
      end

      nxt_s.swPrev = startStopSwitch;
      if (startStopSwitch && !s_ff.swPrev)
      begin
         runReq = 1'b1;
      end
      if (!startStopSwitch && s_ff.swPrev)
      begin
         stopReq = 1'b1;
      end

      vbNew = int'(adcIn.vbus) * VBUS_FS_CV / ADC_FS;
      errEvt = adcValid && (vbNew > OV_LIMIT || vbNew < UV_LIMIT);
      if (adcValid)
      begin
         nxt_s.busVolt = 16'(vbNew);
         nxt_s.cur.u = toMa(adcIn.iu);
         nxt_s.cur.v = toMa(adcIn.iv);
         nxt_s.cur.w = toMa(adcIn.iw);
      end

      if (adcIn.pot >= POT_ZERO_CW)
      begin
         potRpm = int'(adcIn.pot - POT_ZERO_CW) * SPD_MAX_RPM / POT_SPAN;
      end
      else
      begin
         potRpm = -(int'(POT_ZERO_CCW - adcIn.pot) * SPD_MAX_RPM / POT_SPAN);
      end
      if (s_ff.hostSel)
      begin
         nxt_s.speedCmd = s_ff.hostSpd;
      end
      else if (adcValid)
      begin
         nxt_s.speedCmd = 16'(potRpm);
      end

      unique case (s_ff.mode)
         ST_STOP:
         begin
            if (errEvt)
            begin
               nxt_s.mode = ST_FAULT;
            end
            else if (runReq)
            begin
               nxt_s.mode = ST_DRIVE;
               nxt_s.hallPrime = 1'b0;
               nxt_s.hallSeen = 1'b0;
               nxt_s.histCnt = 3'h0;
               nxt_s.secCnt = 16'h0000;
            end
         end
         ST_DRIVE:
         begin
            if (errEvt)
            begin
               nxt_s.mode = ST_FAULT;
            end
            else if (stopReq)
            begin
               nxt_s.mode = ST_STOP;
            end
         end
         ST_FAULT:
         begin
            if (rstReq && !errEvt)
            begin
               nxt_s.mode = ST_STOP;
            end
         end
         // unused code 3 falls back to stop
         default:
         begin
            nxt_s.mode = ST_STOP;
         end
      endcase
      nxt_s.pwmEn = (nxt_s.mode == ST_DRIVE);

      // hall sampling per tick
      // placed after the mode case, so a same-cycle set beats the run clear
      if (s_ff.tick)
      begin
         nxt_s.hallPrev = hallIn;
         nxt_s.hallPrime = 1'b1;
         if (s_ff.secCnt != 16'hFFFF)
         begin
            nxt_s.secCnt = s_ff.secCnt + 16'h0001;
         end
         if (s_ff.hallPrime && hallIn != s_ff.hallPrev)
         begin
            nxt_s.secCnt = 16'h0000;
            nxt_s.hallSeen = 1'b1;
            nxt_s.dirCw = (idxNew == ((idxOld == 3'h5) ? 3'h0 : idxOld + 3'h1));
            nxt_s.baseAng = 16'(int'(idxNew) * REV_Q / SECTORS);
            if (s_ff.hallSeen)
            begin
               nxt_s.hist = {s_ff.hist[4:0], s_ff.secCnt + 16'h0001};
               if (s_ff.histCnt != HIST_FULL)
               begin
                  nxt_s.histCnt = s_ff.histCnt + 3'h1;
               end
            end
         end
      end

      for (int i = 0; i < SECTORS; i++)
      begin
         sumTmp = sumTmp + int'(s_ff.hist[i]);
      end
      nxt_s.revSum = 19'(sumTmp);
      nxt_s.sumValid = (s_ff.histCnt == HIST_FULL) && (s_ff.revSum != 19'h00000);
      // increment per carrier tick
      // zero as soon as validity drops, so no stale speed leaks out
      nxt_s.angInc = (s_ff.sumValid && nxt_s.sumValid) ? 16'(REV_Q / int'(s_ff.revSum)) : 16'h0000;

      vMax = 17'(phaseCmd.u);
      vMin = 17'(phaseCmd.u);
      if (17'(phaseCmd.v) > vMax) vMax = 17'(phaseCmd.v);
      if (17'(phaseCmd.w) > vMax) vMax = 17'(phaseCmd.w);
      if (17'(phaseCmd.v) < vMin) vMin = 17'(phaseCmd.v);
      if (17'(phaseCmd.w) < vMin) vMin = 17'(phaseCmd.w);
      dv = -((vMax + vMin) >>> 1);
      wu = 17'(phaseCmd.u) + dv;
      wv = 17'(phaseCmd.v) + dv;
      ww = 17'(phaseCmd.w) + dv;
      vPeak = mag(wu);
      if (mag(wv) > vPeak) vPeak = mag(wv);
      if (mag(ww) > vPeak) vPeak = mag(ww);

      if (s_ff.svSel)
      begin
         nxt_s.wave.u = wu[15:0];
         nxt_s.wave.v = wv[15:0];
         nxt_s.wave.w = ww[15:0];
         nxt_s.modRatio = (s_ff.busVolt == 16'h0000) ? 16'h0000 :
            16'((int'(vPeak) << MOD_SHIFT) / int'(s_ff.busVolt));
      end
      else
      begin
         nxt_s.wave = phaseCmd;
         nxt_s.modRatio = (s_ff.busVolt == 16'h0000) ? 16'h0000 :
            16'((int'(refVolt) << MOD_SHIFT) / int'(s_ff.busVolt));
      end

      // register reads, data next cycle only
      if (regRd)
      begin
         case (regAddr)
            A_CTRL: nxt_s.rdData = {11'h000, s_ff.svSel, s_ff.hostSel, 3'h0};
            A_HSPD: nxt_s.rdData = s_ff.hostSpd;
            A_STAT: nxt_s.rdData = {11'h000, s_ff.sumValid, s_ff.dirCw, s_ff.pwmEn, s_ff.mode};
            A_SCMD: nxt_s.rdData = s_ff.speedCmd;
            A_VBUS: nxt_s.rdData = s_ff.busVolt;
            A_AINC: nxt_s.rdData = s_ff.angInc;
            A_RSUM: nxt_s.rdData = s_ff.revSum[15:0];
            default: nxt_s.rdData = 16'h0000;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // outputs straight from state
   assign regRdData = s_ff.rdData;
   assign pwmEnable = s_ff.pwmEn;
   assign modeOut = s_ff.mode;
   assign modWave = s_ff.wave;
   assign modRatio = s_ff.modRatio;
   assign phaseCurrent = s_ff.cur;
   assign speedCmd = s_ff.speedCmd;
   assign busVolt = s_ff.busVolt;
   assign angleInc = s_ff.angInc;
   assign baseAngle = s_ff.baseAng;
   assign dirCw = s_ff.dirCw;
   assign speedValid = s_ff.sumValid;

endmodule : hmdc_top
`default_nettype wire

//--- hmdc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module hmdc_top_sva
   import hmdc_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int OV_LIMIT = OV_CV,
   parameter int UV_LIMIT = UV_CV
)(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [15:0] regRdData,
   // pins and samples
   input wire logic startStopSwitch,
   input wire hmdc_adc_t adcIn,
   input wire logic adcValid,
   // watched outputs
   input wire logic pwmEnable,
   input wire hmdc_mode_t modeOut,
   input wire hmdc_phase_t phaseCurrent,
   input wire logic [15:0] busVolt,
   input wire logic [15:0] angleInc,
   input wire logic [15:0] baseAngle,
   input wire logic dirCw,
   input wire logic speedValid
);
   // one clock domain for every check
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_pwm_mode: assert property (pwmEnable == (modeOut == ST_DRIVE))
      else $error("pwm enable disagrees with mode");
   a_fault_exit: assert property ($past(modeOut) == ST_FAULT && modeOut != ST_FAULT |-> modeOut == ST_STOP)
      else $error("fault left to a mode other than stop");
   a_sw_run: assert property (modeOut == ST_STOP && $rose(startStopSwitch) |=> modeOut != ST_STOP)
      else $error("switch rise did not start");
   a_sw_stop: assert property (modeOut == ST_DRIVE && $fell(startStopSwitch) && !regWr |=> modeOut != ST_DRIVE)
      else $error("switch fall did not stop");
   a_rd_idle: assert property (!$past(regRd) |-> regRdData == 16'h0000)
      else $error("read data outside read cycle");
   a_rd_stat: assert property ($past(regRd && regAddr == A_STAT) |->
      regRdData == {11'h000, $past(speedValid), $past(dirCw), $past(pwmEnable), $past(modeOut)})
      else $error("status read wrong");
   a_rd_unmap: assert property ($past(regRd && regAddr > 4'h6) |-> regRdData == 16'h0000)
      else $error("unmapped read not zero");
   a_inc_valid: assert property (!speedValid |-> angleInc == 16'h0000)
      else $error("increment before six sectors");
   a_bus_scale: assert property ($past(adcValid) |-> busVolt == 16'(32'($past(adcIn.vbus)) * 7326 / 4095))
      else $error("bus voltage scaling wrong");
   a_cur_scale: assert property ($past(adcValid) |->
      phaseCurrent.u == 16'(int'($past(adcIn.iu)) * 16500 / 4095 - 8250))
      else $error("phase current scaling wrong");
   a_limit_stop: assert property ($past(adcValid) && (busVolt > OV_LIMIT || busVolt < UV_LIMIT) |-> !pwmEnable)
      else $error("bus voltage limit did not stop pwm");
   a_base_table: assert property (baseAngle inside {16'h0000, 16'h2AAA, 16'h5555, 16'h8000, 16'hAAAA, 16'hD555})
      else $error("base angle off table");
   // main scenarios reached
   cover property (modeOut == ST_FAULT);
   cover property (speedValid && dirCw);
   cover property ($past(regRd && regAddr == A_STAT));
endmodule : hmdc_top_sva
bind hmdc_top hmdc_top_sva #(.TICK_CYCLES(TICK_CYCLES), .OV_LIMIT(OV_LIMIT), .UV_LIMIT(UV_LIMIT)) u_hmdc_top_sva (
   .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
   .startStopSwitch(startStopSwitch), .adcIn(adcIn), .adcValid(adcValid), .pwmEnable(pwmEnable),
   .modeOut(modeOut), .phaseCurrent(phaseCurrent), .busVolt(busVolt), .angleInc(angleInc),
   .baseAngle(baseAngle), .dirCw(dirCw), .speedValid(speedValid));
`default_nettype wire

//--- hmdc_plant.sv
`timescale 1ns/1ps
`default_nettype none
module hmdc_plant
   import hmdc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // scenario controls
   input wire logic hallRun,
   input wire logic [15:0] stepCyc,
   input wire logic [11:0] potCode,
   input wire logic [11:0] vbusCode,
   input wire logic [11:0] curCode,
   // sensor side
   output logic [2:0] hallIn,
   output var hmdc_adc_t adcIn,
   output logic adcValid
);
   logic [15:0] stepCnt; // clocks in current sector
   logic [2:0] idx; // position in hall order
   logic [1:0] smp; // a/d conversion pacing
   hmdc_adc_t sample; // converted codes
   logic [2:0] seq [6] = '{3'h1, 3'h5, 3'h4, 3'h6, 3'h2, 3'h3};
   assign hallIn = seq[idx];
   assign sample = '{potCode, vbusCode, curCode, curCode, curCode};
   // codes only hold while valid, else their bitwise inverse
   assign adcValid = (smp == 2'h3);
   assign adcIn = adcValid ? sample : ~sample;
   // rotor steps a sector each stepCyc clocks, conversions every fourth clock
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stepCnt <= 16'h0000;
         idx <= 3'h0;
         smp <= 2'h0;
      end
      else
      begin
         smp <= smp + 2'h1;
         if (hallRun && stepCnt == stepCyc - 16'h0001)
         begin
            stepCnt <= 16'h0000;
            idx <= (idx == 3'h5) ? 3'h0 : idx + 3'h1;
         end
         else if (hallRun)
            stepCnt <= stepCnt + 16'h0001;
      end
   end
endmodule : hmdc_plant
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import hmdc_pkg::*;
();
   // stimulus
   logic clk, resetn, regWr, regRd, startStopSwitch, hallRun;
   logic [3:0] regAddr;
   logic [15:0] regWrData, refVolt;
   logic [11:0] potCode, vbusCode, curCode;
   hmdc_phase_t phaseCmd;
   // observed
   logic [15:0] regRdData, modRatio, busVolt, angleInc, baseAngle;
   logic signed [15:0] speedCmd;
   logic pwmEnable, dirCw, speedValid, adcValid;
   logic [2:0] hallIn;
   hmdc_adc_t adcIn;
   hmdc_mode_t modeOut;
   hmdc_phase_t modWave, phaseCurrent;
   int fails, nChecks, cyc;
   hmdc_top #(.TICK_CYCLES(10)) u_hmdc_top (.clk(clk), .resetn(resetn), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .startStopSwitch(startStopSwitch), .hallIn(hallIn), .adcIn(adcIn), .adcValid(adcValid),
      .phaseCmd(phaseCmd), .refVolt(refVolt), .pwmEnable(pwmEnable), .modeOut(modeOut),
      .modWave(modWave), .modRatio(modRatio), .phaseCurrent(phaseCurrent), .speedCmd(speedCmd),
      .busVolt(busVolt), .angleInc(angleInc), .baseAngle(baseAngle), .dirCw(dirCw), .speedValid(speedValid));
   hmdc_plant u_hmdc_plant (.clk(clk), .resetn(resetn), .hallRun(hallRun), .stepCyc(16'h0028),
      .potCode(potCode), .vbusCode(vbusCode), .curCode(curCode), .hallIn(hallIn), .adcIn(adcIn),
      .adcValid(adcValid));
   // free running clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask : step
   // register write, then one idle edge
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask : wr
   // register read, data compared in the following cycle
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      @(posedge clk);
      chk(regRdData, e);
   endtask : rd
   task automatic final_report();
      $display("checks %0d mismatches %0d", nChecks, fails);
      if (fails == 0 && nChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         final_report();
      end
   end
   // test sequence
   initial
   begin
      logic [11:0] pots [4];
      int e, bv;
      logic [2:0] pats [6];
      pots = '{12'hFFF, 12'h800, 12'h7FF, 12'h000};
      pats = '{3'h1, 3'h5, 3'h4, 3'h6, 3'h2, 3'h3};
      bv = 2048 * 7326 / 4095;
      {resetn, regWr, regRd, startStopSwitch, hallRun} = 5'h00;
      {regAddr, regWrData, refVolt, phaseCmd} = '0;
      {potCode, vbusCode, curCode} = {12'h800, 12'h800, 12'hFFF};
      step(3);
      resetn <= 1'b1;
      step(1);
      chk(modeOut, ST_STOP);
      rd(A_STAT, 16'h0000);
      rd(4'hF, 16'h0000);
      $display("test reset done");
      step(8);
      chk(busVolt, 16'(bv));
      chk(phaseCurrent.u, 16'h203A);
      curCode <= 12'h000;
      for (int i = 0; i < 4; i++)
      begin
         potCode <= pots[i];
         step(8);
         e = pots[i] >= 12'h800 ? (pots[i] - 2048) * 2400 / 2047 : -((2047 - pots[i]) * 2400 / 2047);
         chk(speedCmd, 16'(e));
      end
      chk(phaseCurrent.w, 16'hDFC6);
      chk(phaseCurrent.v, 16'hDFC6);
      wr(A_CTRL, 16'h0008);
      wr(A_HSPD, 16'h0123);
      step(2);
      chk(speedCmd, 16'h0123);
      rd(A_CTRL, 16'h0008);
      wr(A_CTRL, 16'h0000);
      $display("test scaling done");
      startStopSwitch <= 1'b1;
      step(3);
      chk(modeOut, ST_DRIVE);
      chk(pwmEnable, 1'b1);
      startStopSwitch <= 1'b0;
      step(3);
      chk(modeOut, ST_STOP);
      wr(A_CTRL, 16'h0001);
      step(1);
      chk(modeOut, ST_DRIVE);
      wr(A_CTRL, 16'h0002);
      step(1);
      chk(modeOut, ST_STOP);
      wr(A_CTRL, 16'h0001);
      vbusCode <= 12'hFFF;
      step(8);
      chk(busVolt, 16'h1C9E);
      chk(modeOut, ST_FAULT);
      chk(pwmEnable, 1'b0);
      vbusCode <= 12'h800;
      step(8);
      wr(A_CTRL, 16'h0001);
      step(1);
      chk(modeOut, ST_FAULT);
      wr(A_CTRL, 16'h0004);
      step(1);
      chk(modeOut, ST_STOP);
      $display("test modes done");
      phaseCmd <= '{16'h03E8, 16'hFF38, 16'hFE0C};
      refVolt <= 16'h03E8;
      step(4);
      chk(modWave.u, 16'h03E8);
      chk(modRatio, 16'(1000 * 32768 / bv));
      wr(A_CTRL, 16'h0010);
      step(3);
      chk(modWave.u, 16'(1000 - 250));
      chk(modWave.v, 16'(-200 - 250));
      chk(modWave.w, 16'(-500 - 250));
      chk(modRatio, 16'(750 * 32768 / bv));
      $display("test modulation done");
      wr(A_CTRL, 16'h0001);
      hallRun <= 1'b1;
      step(1);
      chk(speedValid, 1'b0);
      step(480);
      chk(speedValid, 1'b1);
      chk(angleInc, 16'(65536 / 24));
      chk(dirCw, 1'b1);
      rd(A_RSUM, 16'h0018);
      rd(A_STAT, 16'h001D);
      // park the rotor, then the base angle must match the pattern it rests on
      hallRun <= 1'b0;
      step(12);
      for (int i = 0; i < 6; i++)
      begin
         if (pats[i] == hallIn) e = i * 65536 / 6;
      end
      chk(baseAngle, 16'(e));
      $display("test hall done");
      final_report();
   end
endmodule : tb_top
`default_nettype wire
